// File: include/rst_seq_pkg.sv
package rst_seq_pkg;

	// Register map, byte addresses on the AXI4-Lite slave.
	localparam logic [3:0] addr_cause   = 4'h0;
	localparam logic [3:0] addr_clock   = 4'h4;
	localparam logic [3:0] addr_status  = 4'h8;

	// Flag positions in the reset cause control register.
	localparam int bit_power_on   = 0;
	localparam int bit_brownout   = 1;
	localparam int bit_idle       = 2;
	localparam int bit_sleep      = 3;
	localparam int bit_watchdog   = 4;
	localparam int bit_soft_wdog  = 5;
	localparam int bit_software   = 6;
	localparam int bit_pin        = 7;
	localparam int bit_illegal    = 14;
	localparam int bit_trap       = 15;

	// Writable bits: every flag plus the software watchdog enable.
	localparam logic [15:0] cause_mask  = 16'hc0ff;
	localparam logic [15:0] cause_reset = 16'h0003;

	// Clock source codes, three bits as in the oscillator selection field.
	localparam logic [2:0] osc_fast      = 3'h0;
	localparam logic [2:0] osc_fast_pll  = 3'h1;
	localparam logic [2:0] osc_primary   = 3'h2;
	localparam logic [2:0] osc_pri_pll   = 3'h3;
	localparam logic [2:0] osc_second    = 3'h4;
	localparam logic [2:0] osc_low_power = 3'h5;

	// Timing in nanoseconds and the clock period.
	localparam longint clk_period_ns  = 25;
	localparam longint power_on_ns    = 10000;
	localparam longint startup_reg_ns = 20000;
	localparam longint startup_off_ns = 64000000;
	localparam longint state_reset_ns = 20000;
	localparam longint pll_lock_ns    = 20000;
	localparam longint monitor_ns     = 100000;
	localparam int     start_periods  = 1024;

	// Least times round up to whole cycles.
	localparam int power_on_cyc    = int'((power_on_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int startup_reg_cyc = int'((startup_reg_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int startup_off_cyc = int'((startup_off_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int state_reset_cyc = int'((state_reset_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int pll_lock_cyc    = int'((pll_lock_ns + clk_period_ns - 1) / clk_period_ns);
	localparam int monitor_cyc     = int'((monitor_ns + clk_period_ns - 1) / clk_period_ns);

	typedef enum logic [4:0] {
		st_power_on = 5'b00001,
		st_startup  = 5'b00010,
		st_state    = 5'b00100,
		st_monitor  = 5'b01000,
		st_run      = 5'b10000
	} seq_state_t;

endpackage

// File: verilog/reset_cause_and_release_sequencer.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module reset_cause_and_release_sequencer #(
	parameter int startup_off_cycles = rst_seq_pkg::startup_off_cyc,
	parameter int osc_start_count    = rst_seq_pkg::start_periods
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        power_on_event,
	input  wire logic        brownout_event,
	input  wire logic        pin_reset_event,
	input  wire logic        watchdog_event,
	input  wire logic        software_reset_event,
	input  wire logic        illegal_access_event,
	input  wire logic        trap_conflict_event,
	input  wire logic        sleep_entry_event,
	input  wire logic        idle_entry_event,
	input  wire logic        wake_event,
	input  wire logic        watchdog_enable_fuse,
	input  wire logic        clock_switch_enable,
	input  wire logic [2:0]  new_oscillator_fuse_field,
	input  wire logic        regulator_enable,
	input  wire logic        fail_safe_enable,
	input  wire logic        osc_tick,
	input  wire logic        clock_valid,
	output logic             system_reset_signal,
	output logic             code_run,
	output logic             watchdog_run,
	output logic [2:0]       current_oscillator_field,
	output logic             monitor_active,
	output logic             oscillator_fail_trap
);
	import rst_seq_pkg::*;

	// The start-up counter is 10 bits and the delay timer 22 bits wide; larger counts would wrap.
	if (osc_start_count < 1 || osc_start_count > 1024 || startup_off_cycles < 1
		|| startup_off_cycles > 4194303) begin : g_bad_params
		$error("Unsupported timing parameters.");
	end

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        aw_held;
		logic [3:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic [15:0] cause;
		logic [2:0]  osc;
		seq_state_t  state;
		logic [21:0] timer;
		logic [9:0]  osc_start;
		logic        osc_start_done;
		logic [9:0]  lock;
		logic        lock_done;
		logic        in_reset;
		logic        run;
		logic        monitor;
		logic        trap;
	} state_t;

	state_t cur;
	state_t next_cur;

	logic any_reset;
	logic long_reset;
	logic [2:0] pick_osc;
	logic crystal;
	logic pll;
	logic sel_slow;
	logic [21:0] startup_len;

	////////////////////////////////////////////////////////////////////////////
	// Reset classification and clock choice.
	always_comb begin
		any_reset = power_on_event | brownout_event | pin_reset_event | watchdog_event
			| software_reset_event | illegal_access_event | trap_conflict_event;
		long_reset = power_on_event | brownout_event;
		if (clock_switch_enable && !long_reset)
			pick_osc = cur.osc;
		else
			pick_osc = new_oscillator_fuse_field;
		crystal = (pick_osc == osc_primary) || (pick_osc == osc_pri_pll) || (pick_osc == osc_second);
		pll = (pick_osc == osc_fast_pll) || (pick_osc == osc_pri_pll);
		// The monitor delay follows the source in use, not the live fuse field.
		sel_slow = (cur.osc == osc_fast_pll) || (cur.osc == osc_primary) || (cur.osc == osc_pri_pll)
			|| (cur.osc == osc_second);
		startup_len = regulator_enable ? 22'(startup_reg_cyc) : 22'(startup_off_cycles);
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, flags and release sequence.
	always_comb begin
		logic [15:0] wval;
		logic        wr_cause;
		wval = 16'h0000;
		wr_cause = 1'b0;
		next_cur = cur;

		// Write channel: address and data taken in either order.
		if (s_axi_awvalid && cur.awready) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = s_axi_awaddr[3:0];
			next_cur.awready = 1'b0;
		end
		if (s_axi_wvalid && cur.wready) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
			next_cur.wready = 1'b0;
		end
		if (cur.aw_held && cur.w_held && !cur.bvalid) begin
			next_cur.bvalid = 1'b1;
			next_cur.bresp = (cur.aw_addr == addr_cause) ? 2'h0 : 2'h2;
			wr_cause = (cur.aw_addr == addr_cause);
			wval = cur.cause;
			if (cur.w_strb[0])
				wval[7:0] = cur.w_data[7:0];
			if (cur.w_strb[1])
				wval[15:8] = cur.w_data[15:8];
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
			next_cur.aw_held = 1'b0;
			next_cur.w_held = 1'b0;
			next_cur.awready = 1'b1;
			next_cur.wready = 1'b1;
		end

		// Read channel: one outstanding read, decode errors answer SLVERR.
		if (s_axi_arvalid && cur.arready) begin
			next_cur.arready = 1'b0;
			next_cur.rvalid = 1'b1;
			next_cur.rresp = 2'h0;
			case (s_axi_araddr[3:0])
				addr_cause:  next_cur.rdata = {16'h0000, cur.cause};
				addr_clock:  next_cur.rdata = {29'h0, cur.osc};
				addr_status: next_cur.rdata = {27'h0, cur.trap, cur.monitor, cur.run, cur.in_reset, watchdog_run};
				default: begin
					next_cur.rdata = 32'h0;
					next_cur.rresp = 2'h2;
				end
			endcase
		end
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
			next_cur.arready = 1'b1;
		end

		// software flag writes
		// A software write only stores bits; it never feeds the reset sequence.
		if (wr_cause)
			next_cur.cause = (wval & cause_mask) | (cur.cause & ~cause_mask);

		// Hardware clears first, so a set in the same cycle wins.
		// clear on long reset
		if (long_reset) begin
			next_cur.cause[bit_illegal] = 1'b0;
			next_cur.cause[bit_trap] = 1'b0;
			next_cur.cause[bit_software] = 1'b0;
			next_cur.cause[bit_sleep] = 1'b0;
			next_cur.cause[bit_idle] = 1'b0;
			next_cur.cause[bit_watchdog] = 1'b0;
		end
		if (sleep_entry_event || idle_entry_event)
			next_cur.cause[bit_watchdog] = 1'b0;
		if (power_on_event)
			next_cur.cause[bit_pin] = 1'b0;
		if (power_on_event)
			next_cur.cause[bit_power_on] = 1'b1;
		if (long_reset)
			next_cur.cause[bit_brownout] = 1'b1;
		if (illegal_access_event)
			next_cur.cause[bit_illegal] = 1'b1;
		if (watchdog_event)
			next_cur.cause[bit_watchdog] = 1'b1;
		if (trap_conflict_event)
			next_cur.cause[bit_trap] = 1'b1;
		if (software_reset_event)
			next_cur.cause[bit_software] = 1'b1;
		if (sleep_entry_event)
			next_cur.cause[bit_sleep] = 1'b1;
		if (idle_entry_event)
			next_cur.cause[bit_idle] = 1'b1;
		if (pin_reset_event)
			next_cur.cause[bit_pin] = 1'b1;

		// Oscillator start-up and lock timers run on their own.
		// concurrent oscillator waits
		if (!cur.osc_start_done && osc_tick) begin
			next_cur.osc_start = cur.osc_start + 10'h001;
			if (cur.osc_start == 10'(osc_start_count - 1))
				next_cur.osc_start_done = 1'b1;
		end
		if (cur.osc_start_done && !cur.lock_done) begin
			next_cur.lock = cur.lock + 10'h001;
			if (cur.lock == 10'(pll_lock_cyc - 1))
				next_cur.lock_done = 1'b1;
		end

		// Release sequence.
		if (cur.timer != 22'h0)
			next_cur.timer = cur.timer - 22'h000001;
		case (cur.state)
			st_power_on: begin
				if (cur.timer == 22'h0) begin
					next_cur.state = st_startup;
					next_cur.timer = startup_len;
				end
			end
			st_startup: begin
				// A wake from a powered-down state is no reset, so it skips the state reset time.
				if (cur.timer == 22'h0 && !cur.in_reset) begin
					next_cur.state = st_run;
				end else if (cur.timer == 22'h0) begin
					next_cur.state = st_state;
					next_cur.timer = 22'(state_reset_cyc);
				end
			end
			st_state: begin
				if (cur.timer == 22'h0) begin
					next_cur.in_reset = 1'b0;
					next_cur.state = st_monitor;
					next_cur.timer = sel_slow ? 22'(monitor_cyc) : 22'h0;
				end
			end
			st_monitor: begin
				if (cur.timer == 22'h0) begin
					next_cur.state = st_run;
					next_cur.monitor = fail_safe_enable;
					if (fail_safe_enable && !clock_valid) begin
						next_cur.osc = osc_fast;
						next_cur.trap = 1'b1;
						next_cur.osc_start_done = 1'b1;
						next_cur.lock_done = 1'b1;
					end
				end
			end
			st_run: begin
				if (wake_event && regulator_enable) begin
					next_cur.run = 1'b0;
					next_cur.state = st_startup;
					next_cur.timer = 22'(startup_reg_cyc);
				end
			end
			default: next_cur.state = st_run;
		endcase

		next_cur.run = !cur.in_reset && cur.osc_start_done && cur.lock_done && (cur.state == st_run)
			&& !(wake_event && regulator_enable);

		// A new reset restarts the clock waits and the release sequence, not the flags or the bus; picks the path by type.
		if (any_reset) begin
			next_cur.osc = pick_osc;
			next_cur.in_reset = 1'b1;
			next_cur.run = 1'b0;
			next_cur.monitor = 1'b0;
			next_cur.trap = 1'b0;
			next_cur.osc_start = 10'h0;
			next_cur.lock = 10'h0;
			next_cur.osc_start_done = !crystal;
			next_cur.lock_done = !pll;
			if (power_on_event) begin
				next_cur.state = st_power_on;
				next_cur.timer = 22'(power_on_cyc);
			end else if (brownout_event) begin
				next_cur.state = st_startup;
				next_cur.timer = startup_len;
			end else begin
				next_cur.state = st_state;
				next_cur.timer = 22'(state_reset_cyc);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reset values fixed
	// The bus reset behaves as a power-on: the cause register shows both flags.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
			cur.awready <= 1'b1;
			cur.wready <= 1'b1;
			cur.arready <= 1'b1;
			cur.cause <= cause_reset;
			cur.osc <= osc_fast;
			cur.state <= st_power_on;
			cur.timer <= 22'(power_on_cyc);
			cur.in_reset <= 1'b1;
			cur.osc_start_done <= 1'b1;
			cur.lock_done <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs come from the state register, except watchdog_run, which has a register of its own.
	assign s_axi_awready = cur.awready;
	assign s_axi_wready = cur.wready;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = cur.arready;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rresp = cur.rresp;
	assign s_axi_rdata = cur.rdata;
	assign system_reset_signal = cur.in_reset;
	assign code_run = cur.run;
	assign current_oscillator_field = cur.osc;
	assign monitor_active = cur.monitor;
	assign oscillator_fail_trap = cur.trap;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			watchdog_run <= 1'b0;
		else
			watchdog_run <= watchdog_enable_fuse | cur.cause[bit_soft_wdog];
	end

endmodule

// File: testbench/rst_seq_chk.sv
`timescale 1ns/1ps
module rst_seq_chk import rst_seq_pkg::*; #(
	parameter int startup_off_cycles = 50,
	parameter int osc_start_count    = 4
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        pin_reset_event,
	input wire logic        watchdog_enable_fuse,
	input wire logic        system_reset_signal,
	input wire logic        code_run,
	input wire logic        watchdog_run,
	input wire logic [2:0]  current_oscillator_field,
	input wire logic        oscillator_fail_trap
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	int rst_len;
	// Length of the current internal reset, so a short release is caught.
	always_ff @(posedge aclk) begin
		if (!aresetn || !system_reset_signal)
			rst_len <= 0;
		else
			rst_len <= rst_len + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	code_gate_a: assert property (code_run |-> !system_reset_signal)
		else $error("code runs under reset");
	fuse_wdog_a: assert property ($past(aresetn) && $past(watchdog_enable_fuse) |-> watchdog_run)
		else $error("watchdog stopped with fuse set");
	rst_len_a: assert property ($fell(system_reset_signal) |-> rst_len >= 795)
		else $error("reset released too early");
	pin_rel_a: assert property (pin_reset_event |-> ##[795:806] $fell(system_reset_signal))
		else $error("pin reset length wrong");
	trap_fast_rc_a: assert property ($rose(oscillator_fail_trap) |-> current_oscillator_field == osc_fast)
		else $error("trap without fast rc");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	r_err_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3:0] == 4'hc
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	w_err_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[3:0] != 4'h0
		|-> ##[1:4] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("bad write not refused");
	cover property ($rose(code_run));
	cover property ($rose(oscillator_fail_trap));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind reset_cause_and_release_sequencer rst_seq_chk #(.startup_off_cycles(startup_off_cycles),
	.osc_start_count(osc_start_count)) i_rst_seq_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_reset_event, .watchdog_enable_fuse, .system_reset_signal,
	.code_run, .watchdog_run, .current_oscillator_field, .oscillator_fail_trap);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import rst_seq_pkg::*;
	logic        aclk = 0, aresetn = 0, tick = 0, wfuse = 0, cse = 1, regu = 1, fse = 1, cv = 1;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        system_reset_signal, code_run, watchdog_run, monitor_active, oscillator_fail_trap;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [9:0]  ev = 0;
	logic [2:0]  nf = osc_fast, current_oscillator_field;
	logic [7:0]  lf = 8'h49;
	logic [15:0] cause;
	int          fail_count = 0, checked = 0, cyc = 0, n;
	reset_cause_and_release_sequencer #(.startup_off_cycles(50), .osc_start_count(4)) i_reset_cause_and_release_sequencer (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.power_on_event(ev[0]), .brownout_event(ev[1]), .pin_reset_event(ev[2]), .watchdog_event(ev[3]),
		.software_reset_event(ev[4]), .illegal_access_event(ev[5]), .trap_conflict_event(ev[6]),
		.sleep_entry_event(ev[7]), .idle_entry_event(ev[8]), .wake_event(ev[9]), .watchdog_enable_fuse(wfuse),
		.clock_switch_enable(cse), .new_oscillator_fuse_field(nf), .regulator_enable(regu),
		.fail_safe_enable(fse), .osc_tick(tick), .clock_valid(cv), .system_reset_signal, .code_run,
		.watchdog_run, .current_oscillator_field, .monitor_active, .oscillator_fail_trap);
	always #12.5 aclk = ~aclk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Random oscillator ticks, so start-up counting sees uneven spacing.
	always @(posedge aclk) begin
		lf <= lfsr(lf);
		tick <= lf[0];
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			close_out;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task close_out;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Cause flag model: set and clear events per flag.
	function automatic void apply(int e);
		case (e)
			0: cause = 16'h0003;
			1: cause = (cause & 16'h00a1) | 16'h0002;
			7: cause = (cause | 16'h0008) & 16'hffef;
			8: cause = (cause | 16'h0004) & 16'hffef;
			default: cause = cause | (16'h1 << ((e == 2) ? 7 : (e == 3) ? 4 : (e == 4) ? 6 : (e == 5) ? 14 : 15));
		endcase
	endfunction
	task wr(input logic [31:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		@(posedge aclk);
	endtask
	task rd(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	task pulse(input int e);
		ev[e] <= 1;
		@(posedge aclk);
		ev[e] <= 0;
	endtask
	// Measures the reset length against the expected cycles.
	task settle(input int w, input bit cw);
		n = 0;
		repeat (3) @(posedge aclk);
		check(system_reset_signal, 1);
		while (system_reset_signal !== 0) begin
			@(posedge aclk);
			n++;
		end
		check(n + 3 > w - 8 && n + 3 < w + 8, 1);
		while (cw && code_run !== 1) @(posedge aclk);
	endtask
	task automatic wait_for(ref logic s);
		n = 0;
		while (s !== 1 && n < 5000) begin
			@(posedge aclk);
			n++;
		end
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		settle(2000, 1);
		apply(0);
		rd(0);
		check(d, cause);
		wr(0, 32'hffff);
		rd(0);
		check(d, 32'hc0ff);
		check(system_reset_signal, 0);
		wr(0, 0);
		cause = 0;
		wfuse <= 1;
		repeat (2) @(posedge aclk);
		check(watchdog_run, 1);
		wfuse <= 0;
		repeat (2) @(posedge aclk);
		check(watchdog_run, 0);
		rd(32'hc);
		check(r, 2);
		wr(4, 32'h7);
		check(r, 2);
		nf <= osc_primary;
		for (int e = 2; e < 9; e++) begin
			pulse(e);
			apply(e);
			if (e < 7) settle(800, 1);
			else repeat (3) @(posedge aclk);
			rd(0);
			check(d, cause);
			check(current_oscillator_field, osc_fast);
		end
		pulse(1);
		apply(1);
		settle(1600, 0);
		// The crystal is still inside the monitor delay, so no code may run yet.
		check(code_run, 0);
		wait_for(monitor_active);
		check(n > 3950 && n < 4010, 1);
		rd(0);
		check(d, cause);
		check(current_oscillator_field, osc_primary);
		check(oscillator_fail_trap, 0);
		regu <= 0;
		pulse(1);
		settle(850, 1);
		regu <= 1;
		// A wake with the regulator on costs only the start-up time; it is no reset.
		pulse(9);
		repeat (2) @(posedge aclk);
		check(code_run, 0);
		check(system_reset_signal, 0);
		wait_for(code_run);
		check(n > 790 && n < 810, 1);
		cse <= 0;
		nf <= osc_fast_pll;
		pulse(2);
		settle(800, 1);
		rd(4);
		check(d, osc_fast_pll);
		pulse(0);
		apply(0);
		settle(2000, 1);
		rd(0);
		check(d, cause);
		cv <= 0;
		cse <= 1;
		nf <= osc_primary;
		pulse(1);
		settle(1600, 0);
		wait_for(oscillator_fail_trap);
		check(oscillator_fail_trap, 1);
		check(current_oscillator_field, osc_fast);
		close_out;
	end
endmodule
